// ---- common/strap_defs.vh ----
// Constants for the strap decode and DMA sizing block.
`ifndef STRAP_DEFS_VH
`define STRAP_DEFS_VH
`define IO_PORT_BASE_334    10'h334
`define IO_PORT_BASE_330    10'h330
`define IO_PORT_BASE_234    10'h234
`define IO_PORT_BASE_230    10'h230
`define IO_PORT_BASE_134    10'h134
`define IO_PORT_BASE_130    10'h130
`define PORT_CFG_DEFAULT    3'h1
`define FDC_PRI_BASE        10'h3f0
`define FDC_SEC_BASE        10'h370
`define ROM_BASE_DEFAULT    24'h0d_c000
`define ROM_SIZE_BITS       14
`define FDC_IRQ_DEFAULT     3'h6
`define FDC_DMA_DEFAULT     2'h2
`define CLK_PERIOD_NS       10
`define WAIT_100_NS         100
`define WAIT_200_NS         200
`define WAIT_300_NS         300
`define WAIT_100_CYC        (`WAIT_100_NS / `CLK_PERIOD_NS)
`define WAIT_200_CYC        (`WAIT_200_NS / `CLK_PERIOD_NS)
`define WAIT_300_CYC        (`WAIT_300_NS / `CLK_PERIOD_NS)
`define WS_NONE             2'h0
`define WS_100              2'h1
`define WS_200              2'h2
`define WS_300              2'h3
`endif

// ---- core/dma_sizer.v ----
// DMA transfer sizer: splits a byte transfer into 8-bit and 16-bit bus cycles.
`include "strap_defs.vh"

module dma_sizer #(
    parameter AW = 24,
    parameter CW = 16
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire          start,
    input  wire [AW-1:0] start_addr,
    input  wire [CW-1:0] byte_count,
    input  wire          cycle_done,
    output reg           cycle_req_r,
    output reg  [AW-1:0] cycle_addr_r,
    output reg           cycle_word_r,
    output reg           busy_r
);
    reg [CW-1:0] left_r;

    // Word cycles need an even address and two bytes; odd leading or trailing
    // bytes therefore fall out as single byte cycles on their own.
    function next_is_word;
        input [AW-1:0] a;
        input [CW-1:0] n;
        begin
            next_is_word = ~a[0] && (n > {{(CW-1){1'b0}}, 1'b1});
        end
    endfunction

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            left_r       <= {CW{1'b0}};
            cycle_addr_r <= {AW{1'b0}};
            cycle_word_r <= 1'b0;
            cycle_req_r  <= 1'b0;
            busy_r       <= 1'b0;
        end
        else if (start && !busy_r)
        begin
            left_r       <= byte_count;
            cycle_addr_r <= start_addr;
            cycle_word_r <= next_is_word(start_addr, byte_count);
            cycle_req_r  <= (byte_count != {CW{1'b0}});
            busy_r       <= (byte_count != {CW{1'b0}});
        end
        else if (busy_r && cycle_done)
        begin
            if (cycle_word_r)
            begin
                left_r       <= left_r - {{(CW-2){1'b0}}, 2'd2};
                cycle_addr_r <= cycle_addr_r + {{(AW-2){1'b0}}, 2'd2};
                cycle_word_r <= next_is_word(cycle_addr_r + {{(AW-2){1'b0}}, 2'd2},
                                             left_r - {{(CW-2){1'b0}}, 2'd2});
                busy_r       <= (left_r > {{(CW-2){1'b0}}, 2'd2});
                cycle_req_r  <= (left_r > {{(CW-2){1'b0}}, 2'd2});
            end
            else
            begin
                left_r       <= left_r - {{(CW-1){1'b0}}, 1'b1};
                cycle_addr_r <= cycle_addr_r + {{(AW-1){1'b0}}, 1'b1};
                cycle_word_r <= next_is_word(cycle_addr_r + {{(AW-1){1'b0}}, 1'b1},
                                             left_r - {{(CW-1){1'b0}}, 1'b1});
                busy_r       <= (left_r > {{(CW-1){1'b0}}, 1'b1});
                cycle_req_r  <= (left_r > {{(CW-1){1'b0}}, 1'b1});
            end
        end
    end

endmodule

// ---- core/strap_decode.v ----
// Host bus strap decode, ROM wait states and DMA bus mastering.
// Function
// - Four byte ports at strap-selected base
// - ROM reads hold ready low per strap
// - BIOS strap absent means ROM silent
// - ROM window at strap-selected base
// - Drive upper latched address only when enabled
// - Strap disables auto sense; zero length per command
// - Diskette decode at 370 or 3F0 range
// - Diskette disabled ignores all bus signals except the fdc_io_offset address pass-through
// - Diskette interrupt routed to selected channel
// - Diskette request and acknowledge use one channel
// - Adapter arbitrates and masters bus for DMA
// - Odd start address gives first byte cycle
// - Trailing odd byte uses byte cycle
// - Decoded host ports are eight bits wide
`include "strap_defs.vh"

module strap_decode #(
    parameter AW = 24,
    parameter CW = 16
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire [2:0]    port_strap,
    input  wire [1:0]    wait_strap,
    input  wire          bios_en_strap,
    input  wire [AW-1:0] rom_base_strap,
    input  wire          la_en_strap,
    input  wire          sense_off_strap,
    input  wire          fdc_sec_strap,
    input  wire          fdc_en_strap,
    input  wire [2:0]    fdc_irq_strap,
    input  wire [1:0]    fdc_dma_strap,
    input  wire [AW-1:0] host_addr,
    input  wire          host_ior,
    input  wire          host_iow,
    input  wire          host_memr,
    input  wire [7:0]    host_data_in,
    output reg  [7:0]    port_wdata_r,
    output reg  [1:0]    port_sel_r,
    output reg           port_wr_r,
    output reg           port_rd_r,
    output wire          port_hit,
    input  wire [7:0]    port_rdata,
    output reg  [7:0]    host_data_out_r,
    output wire          host_data_oe_n,
    output wire          rom_hit,
    output wire          iochrdy_out,
    output wire          iochrdy_oe_n,
    output wire          fdc_hit,
    output wire [2:0]    fdc_io_offset,
    input  wire          fdc_irq,
    output reg  [7:0]    host_irq_r,
    input  wire          fdc_drq,
    output reg  [3:0]    host_drq_r,
    input  wire [3:0]    host_dack_n,
    output wire          fdc_dack,
    input  wire          sense_len_zero,
    output wire          auto_sense_en,
    input  wire          dma_start,
    input  wire [AW-1:0] dma_addr,
    input  wire [CW-1:0] dma_count,
    output reg           master_req_n_r,
    input  wire          master_ack_n,
    input  wire          bus_cycle_done,
    output wire          dma_cycle_req,
    output wire [AW-1:0] dma_cycle_addr,
    output wire          dma_sbhe_n,
    output wire          dma_busy,
    output wire [2:0]    la_out,
    output wire          la_oe_n
);
    reg  [2:0]    port_cfg_r;
    reg  [1:0]    wait_cfg_r;
    reg           bios_en_r;
    reg  [AW-1:0] rom_base_r;
    reg           la_en_r;
    reg           sense_off_r;
    reg           fdc_sec_r;
    reg           fdc_en_r;
    reg  [2:0]    fdc_irq_r;
    reg  [1:0]    fdc_dma_r;
    reg           cfg_done_r;
    reg  [4:0]    wait_cnt_r;
    reg           rom_wait_r;
    reg           memr_d_r;
    reg           ior_d_r;
    reg  [9:0]    io_base;
    reg  [4:0]    wait_len;
    wire          cycle_word;
    wire          sizer_busy;
    wire [9:0]    fdc_base;

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            port_cfg_r  <= `PORT_CFG_DEFAULT;
            wait_cfg_r  <= `WS_NONE;
            bios_en_r   <= 1'b1;
            rom_base_r  <= `ROM_BASE_DEFAULT;
            la_en_r     <= 1'b1;
            sense_off_r <= 1'b0;
            fdc_sec_r   <= 1'b0;
            fdc_en_r    <= 1'b1;
            fdc_irq_r   <= `FDC_IRQ_DEFAULT;
            fdc_dma_r   <= `FDC_DMA_DEFAULT;
            cfg_done_r  <= 1'b0;
        end
        else if (!cfg_done_r)
        begin
            port_cfg_r  <= port_strap;
            wait_cfg_r  <= wait_strap;
            bios_en_r   <= bios_en_strap;
            rom_base_r  <= rom_base_strap;
            la_en_r     <= la_en_strap;
            sense_off_r <= sense_off_strap;
            fdc_sec_r   <= fdc_sec_strap;
            fdc_en_r    <= fdc_en_strap;
            fdc_irq_r   <= fdc_irq_strap;
            fdc_dma_r   <= fdc_dma_strap;
            cfg_done_r  <= 1'b1;
        end
    end

    always @*
    begin
        case (port_cfg_r)
            3'h0:    io_base = `IO_PORT_BASE_334;
            3'h1:    io_base = `IO_PORT_BASE_330;
            3'h2:    io_base = `IO_PORT_BASE_234;
            3'h3:    io_base = `IO_PORT_BASE_230;
            3'h4:    io_base = `IO_PORT_BASE_134;
            3'h5:    io_base = `IO_PORT_BASE_130;
            default: io_base = `IO_PORT_BASE_330;
        endcase
    end

    // Decode stays quiet until straps are captured, so no stray port answers.
    assign port_hit = cfg_done_r && !dma_busy &&
                      (host_addr[AW-1:10] == {(AW-10){1'b0}}) &&
                      (host_addr[9:2] == io_base[9:2]);

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            port_wdata_r    <= 8'h00;
            port_sel_r      <= 2'h0;
            port_wr_r       <= 1'b0;
            port_rd_r       <= 1'b0;
            host_data_out_r <= 8'h00;
            ior_d_r         <= 1'b0;
        end
        else
        begin
            ior_d_r   <= host_ior && port_hit;
            port_wr_r <= host_iow && port_hit;
            port_rd_r <= host_ior && port_hit && !ior_d_r;
            if (port_hit && (host_iow || host_ior))
            begin
                port_sel_r   <= host_addr[1:0];
                port_wdata_r <= host_data_in;
            end
            host_data_out_r <= port_rdata;
        end
    end

    assign host_data_oe_n = ~(ior_d_r && host_ior && port_hit);

    assign rom_hit = cfg_done_r && bios_en_r && host_memr &&
                     (host_addr[AW-1:`ROM_SIZE_BITS] == rom_base_r[AW-1:`ROM_SIZE_BITS]);

    // Wait lengths are whole clock periods; the part-selects keep them at counter width.
    localparam integer WAIT_100 = `WAIT_100_CYC;
    localparam integer WAIT_200 = `WAIT_200_CYC;
    localparam integer WAIT_300 = `WAIT_300_CYC;

    always @*
    begin
        case (wait_cfg_r)
            `WS_100: wait_len = WAIT_100[4:0];
            `WS_200: wait_len = WAIT_200[4:0];
            `WS_300: wait_len = WAIT_300[4:0];
            default: wait_len = 5'h00;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            wait_cnt_r <= 5'h00;
            rom_wait_r <= 1'b0;
            memr_d_r   <= 1'b0;
        end
        else
        begin
            memr_d_r <= rom_hit;
            if (rom_hit && !memr_d_r && (wait_len != 5'h00))
            begin
                wait_cnt_r <= wait_len - 5'h01;
                rom_wait_r <= 1'b1;
            end
            else if (rom_wait_r)
            begin
                if (wait_cnt_r == 5'h00)
                    rom_wait_r <= 1'b0;
                else
                    wait_cnt_r <= wait_cnt_r - 5'h01;
            end
        end
    end

    // Ready is open drain: driven low only while a wait is running.
    assign iochrdy_out  = 1'b0;
    assign iochrdy_oe_n = ~rom_wait_r;

    assign auto_sense_en = !sense_off_r && !sense_len_zero;

    assign fdc_base = fdc_sec_r ? `FDC_SEC_BASE : `FDC_PRI_BASE;
    assign fdc_hit = cfg_done_r && fdc_en_r && (host_ior || host_iow) &&
                     (host_addr[AW-1:10] == {(AW-10){1'b0}}) &&
                     (host_addr[9:3] == fdc_base[9:3]);
    assign fdc_io_offset = host_addr[2:0];

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            host_irq_r <= 8'h00;
            host_drq_r <= 4'h0;
        end
        else
        begin
            host_irq_r <= (cfg_done_r && fdc_en_r && fdc_irq) ? (8'h01 << fdc_irq_r) : 8'h00;
            host_drq_r <= (cfg_done_r && fdc_en_r && fdc_drq) ? (4'h1 << fdc_dma_r) : 4'h0;
        end
    end

    assign fdc_dack = cfg_done_r && fdc_en_r && !host_dack_n[fdc_dma_r];

    always @(posedge ref_clk)
    begin
        if (rst)
            master_req_n_r <= 1'b1;
        else
            master_req_n_r <= ~(dma_start || sizer_busy);
    end

    dma_sizer #(
        .AW (AW),
        .CW (CW)
    ) u_sizer (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .start        (dma_start),
        .start_addr   (dma_addr),
        .byte_count   (dma_count),
        .cycle_done   (bus_cycle_done && !master_ack_n),
        .cycle_req_r  (dma_cycle_req),
        .cycle_addr_r (dma_cycle_addr),
        .cycle_word_r (cycle_word),
        .busy_r       (sizer_busy)
    );

    assign dma_busy = sizer_busy;
    // Byte cycles on odd addresses use the high lane, so the high enable goes low too.
    assign dma_sbhe_n = ~(cycle_word || dma_cycle_addr[0]);

    assign la_out  = dma_cycle_addr[19:17];
    assign la_oe_n = ~(la_en_r && sizer_busy && !master_ack_n);
endmodule

// ---- tb/host_bus_model.sv ----
// Host side model: grants the bus, ends dma cycles and answers dma requests.
module host_bus_model (
    input  logic       ref_clk,
    input  logic       rst,
    input  logic       master_req_n_r,
    input  logic       dma_cycle_req,
    input  logic       slow,
    input  logic [3:0] host_drq_r,
    output logic       master_ack_n = 1'b1,
    output logic       bus_cycle_done = 1'b0,
    output logic [3:0] host_dack_n = 4'hf
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] wait_r = 3'h0;
    always @(negedge ref_clk)
    begin
        master_ack_n <= rst | master_req_n_r;
        host_dack_n <= ~host_drq_r;
        bus_cycle_done <= 1'b0;
        // A slow host stretches every cycle to test the hold of the cycle outputs.
        if (dma_cycle_req && !master_ack_n && !bus_cycle_done)
        begin
            wait_r <= wait_r + 3'h1;
            if (wait_r >= (slow ? 3'h5 : 3'h1))
            begin
                bus_cycle_done <= 1'b1;
                wait_r <= 3'h0;
            end
        end
    end
endmodule

// ---- tb/strap_decode_monitor.sv ----
// Checker for the strap decode block, bound to its top module.
module strap_decode_chk #(
    parameter AW = 24
) (
    input logic          ref_clk,
    input logic          rst,
    input logic [1:0]    wait_strap,
    input logic          bios_en_strap,
    input logic          la_en_strap,
    input logic          sense_off_strap,
    input logic          fdc_sec_strap,
    input logic          fdc_en_strap,
    input logic [2:0]    fdc_irq_strap,
    input logic [1:0]    fdc_dma_strap,
    input logic [AW-1:0] host_addr,
    input logic          fdc_irq,
    input logic          fdc_drq,
    input logic [3:0]    host_dack_n,
    input logic          sense_len_zero,
    input logic          master_req_n_r,
    input logic          dma_busy,
    input logic          dma_cycle_req,
    input logic          rom_hit,
    input logic          iochrdy_oe_n,
    input logic          fdc_hit,
    input logic [2:0]    fdc_io_offset,
    input logic          fdc_dack,
    input logic [7:0]    host_irq_r,
    input logic [3:0]    host_drq_r,
    input logic          auto_sense_en,
    input logic          la_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Straps are only in force from the second edge after reset.
    logic       up_r = 1'b0;
    logic [5:0] cnt_r = 6'h00;
    always @(posedge ref_clk)
    begin
        up_r <= !rst;
        cnt_r <= (rst || iochrdy_oe_n) ? 6'h00 : cnt_r + 6'h01;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_wait_length: assert property ($rose(iochrdy_oe_n) |->
        cnt_r == wait_strap * 6'h0a) else $error("ready hold length wrong");
    a_wait_cause: assert property ($fell(iochrdy_oe_n) |->
        $past(rom_hit) && wait_strap != 2'h0) else $error("ready held without rom read");
    a_bios_quiet: assert property (up_r && !bios_en_strap |-> !rom_hit)
        else $error("rom answered while disabled");
    a_la_drive: assert property (!la_oe_n |-> la_en_strap && dma_busy)
        else $error("upper address driven wrongly");
    a_sense_gate: assert property (up_r |->
        auto_sense_en == (!sense_off_strap && !sense_len_zero)) else $error("auto sense wrong");
    a_fdc_range: assert property (up_r && fdc_hit |->
        host_addr[9:3] == (fdc_sec_strap ? 7'h6e : 7'h7e) && fdc_io_offset == host_addr[2:0])
        else $error("diskette decode wrong");
    a_fdc_off: assert property (up_r && !fdc_en_strap |-> !fdc_hit)
        else $error("disabled diskette answered");
    a_irq_route: assert property (up_r && fdc_en_strap |->
        host_irq_r == ($past(fdc_irq) ? 8'h01 << fdc_irq_strap : 8'h00))
        else $error("diskette interrupt misrouted");
    a_dma_route: assert property (up_r && fdc_en_strap |->
        host_drq_r == ($past(fdc_drq) ? 4'h1 << fdc_dma_strap : 4'h0)
        && fdc_dack == !host_dack_n[fdc_dma_strap]) else $error("diskette dma misrouted");
    a_bus_master: assert property (dma_cycle_req |-> !master_req_n_r && dma_busy)
        else $error("dma cycle without bus ownership");
    cover property ($rose(iochrdy_oe_n));
    cover property (!la_oe_n);
    cover property ($fell(dma_busy));
    cover property (fdc_hit && fdc_sec_strap);
endmodule

bind strap_decode strap_decode_chk #(.AW(AW)) mon (.*);

// ---- tb/strap_decode_tb.sv ----
// Testbench for the strap decode and dma sizing block.
module strap_decode_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst, bios_en_strap, la_en_strap, sense_off_strap, fdc_sec_strap;
    logic fdc_en_strap, host_ior, host_iow, host_memr, fdc_irq, fdc_drq, sense_len_zero;
    logic dma_start, slow, port_wr_r, port_rd_r, port_hit, host_data_oe_n, rom_hit;
    logic iochrdy_out, iochrdy_oe_n, fdc_hit, fdc_dack, auto_sense_en, master_req_n_r;
    logic master_ack_n, bus_cycle_done, dma_cycle_req, dma_sbhe_n, dma_busy, la_oe_n;
    logic [2:0]  port_strap, fdc_irq_strap, fdc_io_offset, la_out;
    logic [1:0]  wait_strap, fdc_dma_strap, port_sel_r;
    logic [23:0] host_addr, rom_base_strap, dma_addr, dma_cycle_addr, p, fa;
    logic [7:0]  host_data_in, port_rdata, port_wdata_r, host_data_out_r, host_irq_r;
    logic [15:0] dma_count, n;
    logic [3:0]  host_drq_r, host_dack_n;
    logic [9:0]  bases[6] = '{10'h334, 10'h330, 10'h234, 10'h230, 10'h134, 10'h130};
    logic [24:0] got[$], exp[$];
    logic [23:0] starts[6] = '{24'h00_0001, 24'h00_0002, 24'h00_0001, 24'h0a_0003,
                               24'h00_0000, 24'h00_0005};
    logic [15:0] lens[6] = '{16'h0004, 16'h0004, 16'h0001, 16'h0005, 16'h0003, 16'h0000};
    logic [3:0]  seen_la = 4'h0;
    logic [7:0]  cnt;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    strap_decode uut (.*);
    host_bus_model host (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task chk(input logic [24:0] seen, input logic [24:0] want);
        n_compared++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, want);
        end
    endtask
    task tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task probe(input logic [23:0] a);
        host_addr = a;
        #1;
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (dma_cycle_req && bus_cycle_done && !master_ack_n)
            got.push_back({dma_sbhe_n, dma_cycle_addr});
        if (!la_oe_n)
            seen_la = seen_la | {1'b1, la_out};
        if (cyc == 5000)
        begin
            error_cnt++;
            end_of_test;
        end
    end
    initial
    begin
        {host_ior, host_iow, host_memr, fdc_irq, fdc_drq, sense_len_zero, dma_start} = 0;
        {host_addr, host_data_in, port_rdata, dma_addr, dma_count, slow} = 0;
        for (int i = 0; i < 6; i++)
        begin
            port_strap = i;
            wait_strap = i;
            bios_en_strap = i != 5;
            rom_base_strap = 24'h0d_c000 + i * 24'h00_8000;
            la_en_strap = i != 3;
            sense_off_strap = i % 2;
            fdc_sec_strap = i / 2 % 2;
            fdc_en_strap = i != 4;
            fdc_irq_strap = i + 1;
            fdc_dma_strap = i;
            rst = 1'b1;
            tick(8);
            rst = 1'b0;
            tick(2);
            probe(bases[i] + 3);
            chk(port_hit, 1);
            probe(bases[i] + 4);
            chk(port_hit, 0);
            // Captured straps must ignore later strap changes.
            port_strap = ~port_strap;
            probe(bases[i] + 3);
            chk(port_hit, 1);
            host_iow = 1'b1;
            host_data_in = 8'h5a;
            probe(bases[i] + 2);
            tick(1);
            chk({port_wr_r, port_sel_r, port_wdata_r}, {1'b1, 2'h2, 8'h5a});
            host_iow = 1'b0;
            host_ior = 1'b1;
            port_rdata = 8'ha5;
            probe(bases[i] + 1);
            tick(1);
            chk({port_rd_r, port_sel_r, host_data_out_r, host_data_oe_n},
                {1'b1, 2'h1, 8'ha5, 1'b0});
            tick(1);
            chk({port_rd_r, host_data_oe_n}, 2'b00);
            fa = fdc_sec_strap ? 24'h00_0370 : 24'h00_03f0;
            probe(fa + 5);
            chk({fdc_hit, fdc_hit ? fdc_io_offset : 3'h5}, {fdc_en_strap, 3'h5});
            probe(fa ^ 24'h00_0080);
            chk(fdc_hit, 0);
            host_ior = 1'b0;
            fdc_irq = 1'b1;
            fdc_drq = 1'b1;
            tick(2);
            if (fdc_en_strap)
                chk({host_irq_r, host_drq_r, fdc_dack}, {8'h01 << fdc_irq_strap,
                    4'h1 << fdc_dma_strap, 1'b1});
            fdc_irq = 1'b0;
            fdc_drq = 1'b0;
            #1;
            chk(auto_sense_en, !sense_off_strap);
            sense_len_zero = 1'b1;
            #1;
            chk(auto_sense_en, 0);
            sense_len_zero = 1'b0;
            host_memr = 1'b1;
            probe(rom_base_strap - 1);
            chk(rom_hit, 0);
            probe(rom_base_strap + 24'h00_0100);
            chk(rom_hit, bios_en_strap);
            cnt = 0;
            repeat (40)
            begin
                tick(1);
                cnt += !iochrdy_oe_n;
            end
            chk(cnt, bios_en_strap && wait_strap ? wait_strap * 10 : 0);
            chk(iochrdy_out, 0);
            host_memr = 1'b0;
            chk(la_oe_n, 1);
            $display("test %0d done", i);
        end
        for (int j = 0; j < 6; j++)
        begin
            p = starts[j];
            n = lens[j];
            dma_addr = p;
            dma_count = n;
            slow = j % 2;
            exp.delete();
            got.delete();
            while (n > 0)
                if (!p[0] && n > 1)
                begin
                    exp.push_back({1'b0, p});
                    p += 2;
                    n -= 2;
                end
                else
                begin
                    exp.push_back({!p[0], p});
                    p += 1;
                    n -= 1;
                end
            dma_start = 1'b1;
            tick(1);
            dma_start = 1'b0;
            for (int w = 0; w < 200 && dma_busy !== 1'b0; w++)
                tick(1);
            chk(got.size(), exp.size());
            foreach (exp[q]) chk(got[q], exp[q]);
            $display("dma test %0d done", j);
        end
        chk(seen_la, 4'hd);
        end_of_test;
    end
endmodule
